// file: inc/tmoc_consts.svh
// Purpose: Named constants for the timer output compare and PWM block
// Assumes: Six channels, 16-bit counter
// Notes:   Edge/level codes as two-bit fields
`ifndef TMOC_CONSTS_SVH
`define TMOC_CONSTS_SVH
`define TMOC_NCH 6
`define TMOC_NPAIR 3
`define TMOC_CW 16
`define TMOC_CNT_RST 16'h0000
`define TMOC_MOD_RST 16'hffff
`define TMOC_VAL_RST 16'h0000
`define TMOC_CNT_ONE 16'h0001
`define TMOC_ELS_OFF 2'h0
`define TMOC_ELS_TOG 2'h1
`define TMOC_ELS_CLR 2'h2
`define TMOC_ELS_SET 2'h3
`endif

// file: inc/tmoc_pkg.sv
// Purpose: Types for the timer output compare and PWM block
// Assumes: tmoc_consts.svh provides widths
// Notes:   Per-channel control travels as one packed struct
`include "tmoc_consts.svh"
package tmoc_pkg;
    typedef struct packed {
        logic channel_irq_enable;
        logic pair_link_bit;
        logic mode_low_bit;
        logic edge_level_high;
        logic edge_level_low;
        logic toggle_on_overflow;
        logic max_duty_bit;
    } tmoc_ctrl_type;

    typedef struct packed {
        logic [`TMOC_CW-1:0] value;
        logic pin;
        logic flag;
    } tmoc_chan_type;
endpackage : tmoc_pkg

// file: core/tmoc_chan.sv
// Purpose: One compare channel: pin action, event flag, toggle on overflow
// Assumes: Active compare value chosen by the parent
// Notes:   Pin resets low with output disabled
`timescale 1ns/1ps
`include "tmoc_consts.svh"
module tmoc_chan (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Timing
    input wire logic tick,
    input wire logic overflow,
    input wire logic [`TMOC_CW-1:0] count,
    input wire logic [`TMOC_CW-1:0] cmp_value,
    // Control
    input wire tmoc_pkg::tmoc_ctrl_type ctrl,
    input wire logic active,
    input wire logic flag_clear,
    // Results
    output logic pin,
    output logic flag,
    output logic pin_en
);
    import tmoc_pkg::*;
    typedef struct packed {
        logic pin;
        logic flag;
        logic en;
    } tmoc_cst_type;
    tmoc_cst_type s_q, s_d;
    logic match;
    logic full;
    logic [1:0] els;
    always_comb begin
        s_d = s_q;
        els = {ctrl.edge_level_high, ctrl.edge_level_low};
        full = ctrl.max_duty_bit && ctrl.toggle_on_overflow;
        match = tick && active && (count == cmp_value);
        s_d.en = active && (els != `TMOC_ELS_OFF);
        if (match && !full) begin
            unique case (els)
                `TMOC_ELS_TOG: s_d.pin = ~s_q.pin;
                `TMOC_ELS_CLR: s_d.pin = 1'b0;
                `TMOC_ELS_SET: s_d.pin = 1'b1;
                `TMOC_ELS_OFF: s_d.pin = s_q.pin;
            endcase
        end
        if (tick && overflow && active && ctrl.toggle_on_overflow) begin
            if (ctrl.max_duty_bit) begin
                s_d.pin = ~ctrl.edge_level_low;
            end else if (!match) begin
                s_d.pin = ~s_q.pin;
            end
        end
        if (flag_clear) begin
            s_d.flag = 1'b0;
        end
        if (match) begin
            s_d.flag = 1'b1;
        end
        if (srst) begin
            s_d = '0;
        end
    end
    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end
    assign pin = s_q.pin;
    assign flag = s_q.flag;
    assign pin_en = s_q.en;
endmodule : tmoc_chan

// file: core/tmoc_top.sv
// Purpose: Six-channel output compare and PWM with linked buffered pairs
// Assumes: Counter tick comes from an external prescaler; one clock mclk
// Notes:   Control bits are plain ports; writes are one-cycle strobes
`timescale 1ns/1ps
`include "tmoc_consts.svh"
// Function
// - Match sets, clears or toggles pin
// - Match may request a channel interrupt
// - Unbuffered writes replace compare value immediately
// - Match only when counter reaches value
// - Pair link joins even and odd channels
// - Inactive set takes control at overflow
// - Last written set controls after overflow
// - Even control governs pair; odd ignored
// - Odd pin released to general I/O
// - Toggle on overflow forms PWM period
// - Period is modulo plus one counts
// - Pulse width equals compare value counts
// - Link bit overrides low mode bit
// - No overflow toggle gives zero duty
// - Max duty with toggle gives full duty
// - Match sets flag; enable gates request
module tmoc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Counter control
    input wire logic count_tick,
    input wire logic [`TMOC_CW-1:0] counter_modulo_regs,
    // Channel control
    input wire tmoc_pkg::tmoc_ctrl_type [`TMOC_NCH-1:0] chan_ctrl,
    input wire logic [`TMOC_NCH-1:0] value_wr,
    input wire logic [`TMOC_CW-1:0] value_wdata,
    input wire logic [`TMOC_NCH-1:0] flag_clear,
    // Pins
    output logic [`TMOC_NCH-1:0] chan_pin,
    output logic [`TMOC_NCH-1:0] chan_pin_en,
    // Status
    output logic [`TMOC_NCH-1:0] channel_event_flag,
    output logic [`TMOC_NCH-1:0] chan_irq,
    output logic [`TMOC_NPAIR-1:0] pair_odd_active,
    output logic [`TMOC_CW-1:0] count
);
    import tmoc_pkg::*;
    typedef struct packed {
        logic [`TMOC_CW-1:0] count;
        logic [`TMOC_NCH-1:0][`TMOC_CW-1:0] value;
        logic [`TMOC_NPAIR-1:0] sel_odd;
        logic [`TMOC_NPAIR-1:0] last_odd;
        logic [`TMOC_NCH-1:0] irq;
        logic [`TMOC_NCH-1:0] pin;
        logic [`TMOC_NCH-1:0] pin_en;
        logic [`TMOC_NCH-1:0] flag;
    } tmoc_st_type;
    tmoc_st_type s_q, s_d;
    logic overflow;
    logic [`TMOC_CW-1:0] count_nxt;
    logic [`TMOC_NCH-1:0] active;
    logic [`TMOC_NCH-1:0][`TMOC_CW-1:0] cmp_value;
    logic [`TMOC_NCH-1:0] c_pin, c_flag, c_en;
    logic [`TMOC_NPAIR-1:0] linked;

    // ------------------------------------------------------------
    // Pair decode
    // ------------------------------------------------------------
    function automatic logic is_linked(input tmoc_ctrl_type c);
        is_linked = c.pair_link_bit;
    endfunction : is_linked

    function automatic logic is_compare(input tmoc_ctrl_type c);
        is_compare = c.pair_link_bit || c.mode_low_bit;
    endfunction : is_compare

    assign overflow = (s_q.count == counter_modulo_regs);
    // Count being entered; channels compare it so a pulse spans exactly the value
    assign count_nxt = overflow ? `TMOC_CNT_RST : s_q.count + `TMOC_CNT_ONE;

    always_comb begin
        for (int p = 0; p < `TMOC_NPAIR; p++) begin
            linked[p] = is_linked(chan_ctrl[2*p]);
            active[2*p] = is_compare(chan_ctrl[2*p]);
            active[2*p+1] = !linked[p] && is_compare(chan_ctrl[2*p+1]);
            cmp_value[2*p] = linked[p] && s_q.sel_odd[p] ?
                s_q.value[2*p+1] : s_q.value[2*p];
            cmp_value[2*p+1] = s_q.value[2*p+1];
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < `TMOC_NCH; i++) begin : g_ch
        tmoc_chan u_chan (
            .mclk(mclk),
            .srst(srst),
            .tick(count_tick),
            .overflow(overflow),
            .count(count_nxt),
            .cmp_value(cmp_value[i]),
            .ctrl(chan_ctrl[i]),
            .active(active[i]),
            .flag_clear(flag_clear[i]),
            .pin(c_pin[i]),
            .flag(c_flag[i]),
            .pin_en(c_en[i])
        );
    end

    // ------------------------------------------------------------
    // State update
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (count_tick) begin
            s_d.count = count_nxt;
        end
        for (int i = 0; i < `TMOC_NCH; i++) begin
            if (value_wr[i]) begin
                s_d.value[i] = value_wdata;
            end
        end
        for (int p = 0; p < `TMOC_NPAIR; p++) begin
            if (!linked[p]) begin
                s_d.sel_odd[p] = 1'b0;
                s_d.last_odd[p] = 1'b0;
            end else begin
                if (value_wr[2*p+1]) begin
                    s_d.last_odd[p] = 1'b1;
                end else if (value_wr[2*p]) begin
                    s_d.last_odd[p] = 1'b0;
                end
                if (count_tick && overflow) begin
                    s_d.sel_odd[p] = s_d.last_odd[p];
                end
            end
        end
        for (int i = 0; i < `TMOC_NCH; i++) begin
            s_d.irq[i] = c_flag[i] && chan_ctrl[i].channel_irq_enable;
        end
        s_d.pin = c_pin;
        s_d.pin_en = c_en;
        s_d.flag = c_flag;
        if (srst) begin
            s_d = '0;
            s_d.count = `TMOC_CNT_RST;
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    assign chan_pin = s_q.pin;
    assign chan_pin_en = s_q.pin_en;
    assign channel_event_flag = s_q.flag;
    assign chan_irq = s_q.irq;
    assign pair_odd_active = s_q.sel_odd;
    assign count = s_q.count;
endmodule : tmoc_top

// file: tb/tmoc_asserts.sv
// Purpose: Port assertions for tmoc_top
// Assumes: Latencies as handed over
// Notes:   Bound to every tmoc_top
`timescale 1ns/1ps
`include "tmoc_consts.svh"
module tmoc_asserts import tmoc_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Inputs
    input wire logic count_tick,
    input wire logic [`TMOC_CW-1:0] counter_modulo_regs,
    input wire tmoc_pkg::tmoc_ctrl_type [`TMOC_NCH-1:0] chan_ctrl,
    input wire logic [`TMOC_NCH-1:0] flag_clear,
    // Outputs
    input wire logic [`TMOC_NCH-1:0] chan_pin_en,
    input wire logic [`TMOC_NCH-1:0] channel_event_flag,
    input wire logic [`TMOC_NCH-1:0] chan_irq,
    input wire logic [`TMOC_NPAIR-1:0] pair_odd_active,
    input wire logic [`TMOC_CW-1:0] count
);
    logic ovf;
    logic [`TMOC_NCH-1:0] ien;
    assign ovf = count_tick && count == counter_modulo_regs;
    always_comb begin
        for (int i = 0; i < `TMOC_NCH; i++) begin
            ien[i] = chan_ctrl[i].channel_irq_enable;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_wrap; ovf |=> count == 16'h0000; endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_inc; count_tick && !ovf |=> count == $past(count) + 16'h0001; endproperty
    a_inc: assert property (p_inc) else $error("no count");
    property p_hold; !count_tick |=> $stable(count); endproperty
    a_hold: assert property (p_hold) else $error("count moved");
    property p_rst; $past(srst) |-> chan_pin_en == 6'h00 && pair_odd_active == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_irq; chan_irq == (channel_event_flag & $past(ien)); endproperty
    a_irq: assert property (p_irq) else $error("irq gating");
    property p_odd; chan_ctrl[2].pair_link_bit [*3] |-> !chan_pin_en[3]; endproperty
    a_odd: assert property (p_odd) else $error("odd pin driven");
    property p_frise; $rose(channel_event_flag[0]) |-> $past(count_tick, 2); endproperty
    a_frise: assert property (p_frise) else $error("flag no tick");
    property p_fclr; flag_clear[0] && !count_tick |-> ##2 !channel_event_flag[0]; endproperty
    a_fclr: assert property (p_fclr) else $error("flag kept");
    property p_pair;
        $changed(pair_odd_active[1]) && $past(chan_ctrl[2].pair_link_bit) && !$past(srst)
            |-> $past(ovf);
    endproperty
    a_pair: assert property (p_pair) else $error("swap off overflow");
endmodule : tmoc_asserts
bind tmoc_top tmoc_asserts u_chk (.mclk(mclk), .srst(srst), .count_tick(count_tick),
    .counter_modulo_regs(counter_modulo_regs), .chan_ctrl(chan_ctrl), .flag_clear(flag_clear),
    .chan_pin_en(chan_pin_en), .channel_event_flag(channel_event_flag), .chan_irq(chan_irq),
    .pair_odd_active(pair_odd_active), .count(count));

// file: tb/tb.sv
// Purpose: Directed test of tmoc_top
// Assumes: Modulo 9 gives a ten-cycle period
// Notes:   Tick paused only for the flag clear
`timescale 1ns/1ps
`include "tmoc_consts.svh"
module tb;
    import tmoc_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic tick = 1'b1;
    tmoc_ctrl_type [`TMOC_NCH-1:0] ctrl = '0;
    logic [`TMOC_NCH-1:0] wr = 6'h00, fclr = 6'h00, pin, pen, flag, irq;
    logic [`TMOC_CW-1:0] wdata = 16'h0000, cnt;
    logic [`TMOC_CW-1:0] modv = 16'h0009;
    logic [`TMOC_NPAIR-1:0] odd;
    int fail_count = 0, num_checks = 0;
    always #50 mclk = ~mclk;
    tmoc_top DUT (.mclk(mclk), .srst(srst), .count_tick(tick), .counter_modulo_regs(modv),
        .chan_ctrl(ctrl), .value_wr(wr), .value_wdata(wdata), .flag_clear(fclr),
        .chan_pin(pin), .chan_pin_en(pen), .channel_event_flag(flag), .chan_irq(irq),
        .pair_odd_active(odd), .count(cnt));
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wval(input int ch, input logic [15:0] v);
        wdata = v;
        wr[ch] = 1'b1;
        step(1);
        wr = 6'h00;
        step(1);
    endtask : wval
    task automatic duty(input int ch, input logic [31:0] exp);
        logic [31:0] h;
        h = 32'h0;
        step(30);
        repeat (10) begin
            h = h + pin[ch];
            step(1);
        end
        chk("high cycles", h, exp);
    endtask : duty
    task complete_run;
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    initial begin
        #100000;
        fail_count++;
        complete_run;
    end
    initial begin
        step(4);
        srst = 1'b0;
        step(1);
        chk("pin enables", pen, 32'h0);
        chk("odd active", odd, 32'h0);
        wval(0, 16'h0003);
        ctrl[0] = 7'h5a;
        duty(0, 32'h3);
        chk("pin enable 0", pen[0], 32'h1);
        chk("flag 0", flag[0], 32'h1);
        chk("irq 0", irq[0], 32'h1);
        tick = 1'b0;
        fclr[0] = 1'b1;
        step(1);
        fclr = 6'h00;
        tick = 1'b1;
        step(1);
        chk("flag 0 cleared", flag[0], 32'h0);
        ctrl[0] = 7'h58;
        duty(0, 32'h0);
        ctrl[0] = 7'h5b;
        duty(0, 32'ha);
        wval(2, 16'h0002);
        ctrl[3] = 7'h2d;
        ctrl[2] = 7'h3a;
        duty(2, 32'h2);
        chk("pin enable 3", pen[3], 32'h0);
        chk("odd active", odd[1], 32'h0);
        chk("irq 2", irq[2], 32'h0);
        wval(3, 16'h0005);
        duty(2, 32'h5);
        chk("odd active", odd[1], 32'h1);
        wval(2, 16'h0001);
        duty(2, 32'h1);
        chk("odd active", odd[1], 32'h0);
        wval(4, 16'h0004);
        ctrl[4] = 7'h1a;
        duty(4, 32'h4);
        while (cnt != 16'h0005) step(1);
        wval(4, 16'h0002);
        duty(4, 32'h2);
        while (cnt != 16'h0000) step(1);
        wval(4, 16'h0006);
        duty(4, 32'h6);
        while (cnt != 16'h0000) step(1);
        modv = 16'h0004;
        duty(2, 32'h2);
        srst = 1'b1;
        step(2);
        srst = 1'b0;
        step(1);
        chk("pin enables", pen, 32'h0);
        chk("odd active", odd, 32'h0);
        chk("flags", flag, 32'h0);
        complete_run;
    end
endmodule : tb
